// *** hdl/sas_attr_lookup.sv ***
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_attr_lookup
    import sas_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           load,
    input  wire logic           relocation,
    input  wire logic [31:0]    addr,
    input  wire sas_kind_t      kind,
    input  wire sas_tlb_t       tlb_entry,
    input  wire sas_real_regs_t rm_regs,
    output sas_attr_t           attr_q
);

    function automatic logic region_bit(input logic [31:0] r, input logic [31:0] a);
        region_bit = r[a[`SAS_REGION_MSB:`SAS_REGION_LSB]];
    endfunction

    sas_attr_t attr_d;
    logic      rm_cache;

    always_comb begin
        rm_cache = (kind == SAS_FETCH) ? region_bit(rm_regs.instr_cacheability_reg, addr)
                                       : region_bit(rm_regs.data_cacheability_reg, addr);
        if (relocation) begin
            attr_d.write_through = tlb_entry.write_through;   // see (R19)
            attr_d.cacheable     = ~tlb_entry.cache_inhibit;  // see (R15)
            attr_d.fenced        = tlb_entry.guarded;         // see (R5)
            attr_d.custom_tag    = tlb_entry.custom_tag;
            attr_d.little_endian = tlb_entry.little_endian;
            attr_d.no_exec       = ~tlb_entry.executable;
        end else begin
            attr_d.write_through = region_bit(rm_regs.write_through_reg, addr); // see (R25)
            attr_d.cacheable     = rm_cache;                                     // see (R16)
            attr_d.fenced        = region_bit(rm_regs.real_mode_fence_register, addr); // see (R5)
            attr_d.custom_tag    = region_bit(rm_regs.custom_tag_reg, addr);
            attr_d.little_endian = region_bit(rm_regs.byte_order_reg, addr);
            attr_d.no_exec       = `SAS_RESET_BIT;
        end
    end

    // Coherence field is never looked at
    always_ff @(posedge clk or negedge rst_n) begin // see (R18)
        if (!rst_n) begin
            attr_q <= '0;
        end else if (load) begin
            attr_q <= attr_d; // see (R26)
        end
    end

endmodule

// *** hdl/sas_params.svh ***
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// Speculative fetch budget after a prediction
`define SAS_CACHED_SPEC_MAX   5
`define SAS_UNCACHED_SPEC_MAX 2
`define SAS_SPEC_CNT_W        3

// Region select: five top address bits, 128 MB each
`define SAS_REGION_MSB        31
`define SAS_REGION_LSB        27

// Real-mode physical page of 1 KB
`define SAS_PAGE_LSB          10

// Outstanding count/return register updates
`define SAS_PEND_W            4

// Reset value of control flops
`define SAS_RESET_BIT         1'b0

`endif

// *** hdl/sas_pkg.sv ***
package sas_pkg;

    typedef enum logic [1:0] {
        SAS_FETCH = 2'b00,
        SAS_LOAD  = 2'b01,
        SAS_STORE = 2'b10
    } sas_kind_t;

    typedef enum logic [1:0] {
        SAS_ST_IDLE = 2'b00,
        SAS_ST_LOOK = 2'b01,
        SAS_ST_HOLD = 2'b10
    } sas_state_t;

    // Translation entry attribute fields
    typedef struct packed {
        logic write_through;
        logic cache_inhibit;
        logic coherent;
        logic guarded;
        logic custom_tag;
        logic little_endian;
        logic executable;
    } sas_tlb_t;

    // Real-mode storage-attribute control registers, bit n = region n
    typedef struct packed {
        logic [31:0] write_through_reg;
        logic [31:0] data_cacheability_reg;
        logic [31:0] instr_cacheability_reg;
        logic [31:0] real_mode_fence_register;
        logic [31:0] custom_tag_reg;
        logic [31:0] byte_order_reg;
    } sas_real_regs_t;

    // Resolved attribute set for one access
    typedef struct packed {
        logic write_through;
        logic cacheable;
        logic fenced;
        logic custom_tag;
        logic little_endian;
        logic no_exec;
    } sas_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        sas_kind_t   kind;
        sas_attr_t   attr;
        logic        use_cache;
        logic        use_memory;
        logic        allocate;
    } sas_issue_t;

endpackage

// *** hdl/sas_spec_budget.sv ***
`timescale 1ns/1ps
`include "sas_params.svh"

module sas_spec_budget #(
    parameter int CNT_W = `SAS_SPEC_CNT_W
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic fetch_strobe,
    input  wire logic cacheable,
    output logic      allow
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;

    assign limit = cacheable ? CNT_W'(`SAS_CACHED_SPEC_MAX) : CNT_W'(`SAS_UNCACHED_SPEC_MAX);
    assign allow = (cnt_q < limit); // see (R2)

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (fetch_strobe && allow) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

endmodule

// *** hdl/sas_spec_ctl.sv ***
`timescale 1ns/1ps
`include "sas_params.svh"

//
// Operation
// (R1) Data loads never issued speculatively; the code issues speculative load hits and holds only speculative load misses
// (R2) Speculative fetch budget: five cached, two uncached
// (R3) Count/return branch waits older register updates
// (R4) Fenced access held until no longer speculative
// (R5) Fence from real register or translation entry
// (R6) Fenced cached load may proceed speculatively
// (R7) Real-mode fenced fetch: cached or adjacent page
// (R8) Virtual fenced/no-execute fetch raises storage interrupt; the code raises it only on a cache miss and issues a hit
// (R9) Unconditional branch stops sequential fetch, redirects
// (R10) System call and return are not breaks
// (R11) Pending count write blocks count-branch fetching
// (R12) Trap execution suppresses speculative prefetch
// (R13) Write-back: hit updates line, miss allocates
// (R14) Write-through: hit both, miss memory only
// (R15) Virtual mode: bypass attribute one means uncached
// (R16) Real mode: cacheability register one enables caching
// (R17) Software avoids cached targets marked bypass
// (R18) Coherence attribute has no effect
// (R19) Attributes from entry or real-mode registers
// (R20) Five attributes: policy, bypass, fence, tag, order
// (R21) Fence clear allows speculative access; the code still holds unfenced speculative load misses and stores
// (R22) Fence set blocks prefetch and speculative loads
// (R23) Byte order: zero big, one little
// (R24) Tagged store with enable raises data interrupt
// (R25) Each register bit covers one 128 MB region
// (R26) One resolved attribute set before issue
module sas_spec_ctl
    import sas_pkg::*;
#(
    parameter int PEND_W = `SAS_PEND_W
) (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic           instruction_relocation_flag,
    input  wire sas_real_regs_t rm_regs,
    input  wire sas_tlb_t       tlb_entry,
    input  wire logic           custom_tag_store_exc_enable,
    input  wire logic           req_valid,
    input  wire sas_kind_t      req_kind,
    input  wire logic [31:0]    req_addr,
    input  wire logic           req_speculative,
    input  wire logic           req_cache_hit,
    input  wire logic           req_seq_needed,
    input  wire logic [31:0]    prev_instr_addr,
    input  wire logic           uncond_branch_fetched,
    input  wire logic           branch_target_fetched,
    input  wire logic           spec_fetch_strobe,
    input  wire logic           spec_fetch_cacheable,
    input  wire logic           branch_resolved,
    input  wire logic           ctr_branch_predicted,
    input  wire logic           lr_branch_predicted,
    input  wire logic           ctr_write_issue,
    input  wire logic           ctr_write_done,
    input  wire logic           lr_write_issue,
    input  wire logic           lr_write_done,
    input  wire logic           conditional_trap_instr,
    output logic                req_ready,
    output logic                issue_valid,
    output sas_issue_t          issue,
    output logic                instr_storage_irq,
    output logic                data_storage_irq,
    output logic                spec_fetch_allow,
    output logic                seq_fetch_stop,
    output logic                fetch_redirect
);

    function automatic logic adjacent_page(input logic [31:0] cur, input logic [31:0] prev);
        logic [31-`SAS_PAGE_LSB:0] cp;
        logic [31-`SAS_PAGE_LSB:0] pp;
        cp = cur[31:`SAS_PAGE_LSB];
        pp = prev[31:`SAS_PAGE_LSB];
        adjacent_page = (cp == pp) || (cp == pp + 1'b1);
    endfunction

    function automatic logic [PEND_W-1:0] pend_next(input logic [PEND_W-1:0] c,
                                                      input logic inc,
                                                      input logic dec);
        pend_next = c;
        if (inc && !dec) begin
            pend_next = c + PEND_W'(1);
        end else if (dec && !inc && (c != '0)) begin
            pend_next = c - PEND_W'(1);
        end
    endfunction

    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // Speculative fetch gating
    logic [PEND_W-1:0] ctr_pend_q;
    logic [PEND_W-1:0] lr_pend_q;
    logic              budget_ok;
    logic              allow_d;
    logic              seq_stop_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctr_pend_q <= '0;
            lr_pend_q  <= '0;
        end else begin
            ctr_pend_q <= pend_next(ctr_pend_q, ctr_write_issue, ctr_write_done); // see (R11)
            lr_pend_q  <= pend_next(lr_pend_q, lr_write_issue, lr_write_done);    // see (R3)
        end
    end

    sas_spec_budget #(
        .CNT_W (`SAS_SPEC_CNT_W)
    ) u_budget (
        .clk          (clk),
        .rst_n        (rst_n),
        .clear        (branch_resolved),
        .fetch_strobe (spec_fetch_strobe),
        .cacheable    (spec_fetch_cacheable),
        .allow        (budget_ok)
    );

    always_comb begin
        allow_d = budget_ok; // see (R2)
        if (ctr_branch_predicted && (ctr_pend_q != '0)) begin
            allow_d = 1'b0; // see (R3) see (R11)
        end
        if (lr_branch_predicted && (lr_pend_q != '0)) begin
            allow_d = 1'b0; // see (R3)
        end
        if (conditional_trap_instr) begin
            allow_d = 1'b0; // see (R12)
        end
        if (seq_stop_q || uncond_branch_fetched) begin
            allow_d = 1'b0; // see (R9)
        end
    end

    // Only unconditional branches stop sequential fetch; call and return do not
    always_ff @(posedge clk or negedge rst_n) begin // see (R10)
        if (!rst_n) begin
            seq_stop_q     <= `SAS_RESET_BIT;
            fetch_redirect <= `SAS_RESET_BIT;
        end else begin
            fetch_redirect <= uncond_branch_fetched; // see (R9)
            if (uncond_branch_fetched) begin
                seq_stop_q <= 1'b1;
            end else if (branch_target_fetched) begin
                seq_stop_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_fetch_allow <= `SAS_RESET_BIT;
            seq_fetch_stop   <= `SAS_RESET_BIT;
        end else begin
            spec_fetch_allow <= allow_d;
            seq_fetch_stop   <= seq_stop_q || uncond_branch_fetched;
        end
    end

    // Access sequencing
    sas_state_t  state_q;
    sas_state_t  state_d;
    logic        take;
    logic [31:0] addr_q;
    sas_kind_t   kind_q;
    logic        hit_q;
    logic        seq_q;
    logic [31:0] prev_q;
    sas_attr_t   attr;

    assign take = (state_q == SAS_ST_IDLE) && req_valid && req_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            kind_q <= SAS_FETCH;
            hit_q  <= 1'b0;
            seq_q  <= 1'b0;
            prev_q <= '0;
        end else if (take) begin
            addr_q <= req_addr;
            kind_q <= req_kind;
            hit_q  <= req_cache_hit;
            seq_q  <= req_seq_needed;
            prev_q <= prev_instr_addr;
        end
    end

    sas_attr_lookup u_lookup (
        .clk        (clk),
        .rst_n      (rst_n),
        .load       (take),
        .relocation (instruction_relocation_flag),
        .addr       (req_addr),
        .kind       (req_kind),
        .tlb_entry  (tlb_entry),
        .rm_regs    (rm_regs),
        .attr_q     (attr)
    );

    logic virt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            virt_q <= 1'b0;
        end else if (take) begin
            virt_q <= instruction_relocation_flag;
        end
    end

    // Decision on the resolved attributes
    logic       blocked;
    logic       isi_d;
    logic       dsi_d;
    logic       go_d;
    sas_issue_t issue_d;

    always_comb begin
        blocked = 1'b0;
        isi_d   = 1'b0;
        dsi_d   = 1'b0;
        case (kind_q)
            SAS_FETCH: begin
                if (virt_q && (attr.fenced || attr.no_exec) && !hit_q) begin
                    isi_d = 1'b1; // see (R8)
                end else if (attr.fenced && req_speculative && !hit_q) begin
                    blocked = !(!virt_q && seq_q && adjacent_page(addr_q, prev_q)); // see (R7)
                end else if (req_speculative && !spec_fetch_allow) begin
                    blocked = 1'b1; // see (R2) see (R12)
                end
            end
            SAS_LOAD: begin
                blocked = req_speculative && !hit_q; // see (R1) see (R6) see (R22)
            end
            SAS_STORE: begin
                if (attr.custom_tag && custom_tag_store_exc_enable) begin
                    dsi_d = 1'b1; // see (R24)
                end else begin
                    blocked = req_speculative; // see (R4)
                end
            end
            default: begin
                blocked = 1'b0;
            end
        endcase
        // The unfenced override below covers speculative fetches only, not loads or stores
        if (!attr.fenced && (kind_q == SAS_FETCH) && !isi_d && spec_fetch_allow) begin
            blocked = 1'b0; // see (R21)
        end
        go_d = !blocked && !isi_d && !dsi_d;
    end

    always_comb begin
        issue_d.addr       = addr_q;
        issue_d.kind       = kind_q;
        issue_d.attr       = attr; // see (R20) see (R23) see (R26)
        issue_d.use_cache  = attr.cacheable;
        issue_d.use_memory = !attr.cacheable; // see (R15) see (R16)
        issue_d.allocate   = 1'b0;
        if ((kind_q == SAS_STORE) && attr.cacheable) begin
            if (attr.write_through) begin
                issue_d.use_cache  = hit_q;  // see (R14)
                issue_d.use_memory = 1'b1;
                issue_d.allocate   = 1'b0;
            end else begin
                issue_d.use_cache  = 1'b1;   // see (R13)
                issue_d.use_memory = 1'b0;
                issue_d.allocate   = !hit_q;
            end
        end else if (attr.cacheable) begin
            issue_d.allocate = !hit_q;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            SAS_ST_IDLE: begin
                if (take) begin
                    state_d = SAS_ST_LOOK;
                end
            end
            SAS_ST_LOOK,
            SAS_ST_HOLD: begin
                state_d = blocked ? SAS_ST_HOLD : SAS_ST_IDLE; // see (R4)
            end
            default: begin
                state_d = SAS_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= SAS_ST_IDLE;
            req_ready <= `SAS_RESET_BIT;
        end else begin
            state_q   <= state_d;
            req_ready <= (state_d == SAS_ST_IDLE);
        end
    end

    logic decide;

    assign decide = (state_q == SAS_ST_LOOK) || (state_q == SAS_ST_HOLD);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            issue_valid       <= `SAS_RESET_BIT;
            issue             <= '0;
            instr_storage_irq <= `SAS_RESET_BIT;
            data_storage_irq  <= `SAS_RESET_BIT;
        end else begin
            issue_valid       <= decide && go_d;
            instr_storage_irq <= decide && isi_d;
            data_storage_irq  <= decide && dsi_d;
            if (decide && go_d) begin
                issue <= issue_d;
            end
        end
    end

endmodule

// *** tb/sas_mem_model.sv ***
`timescale 1ns/1ps
module sas_mem_model
    import sas_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       issue_valid,
    input  wire sas_issue_t issue,
    output logic [7:0]      mem_writes
);
    // Counts stores reaching memory; no cached bypass target is sent
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_writes <= 8'h00;
        end else if (issue_valid && issue.use_memory && issue.kind == SAS_STORE) begin
            mem_writes <= mem_writes + 8'h01;
        end
    end
endmodule

// *** tb/sas_spec_ctl_sva.sv ***
`timescale 1ns/1ps
module sas_spec_ctl_sva
    import sas_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       req_valid,
    input wire logic       req_speculative,
    input wire logic       uncond_branch_fetched,
    input wire logic       conditional_trap_instr,
    input wire logic       req_ready,
    input wire logic       issue_valid,
    input wire sas_issue_t issue,
    input wire logic       instr_storage_irq,
    input wire logic       data_storage_irq,
    input wire logic       spec_fetch_allow,
    input wire logic       seq_fetch_stop,
    input wire logic       fetch_redirect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_one_answer: assert property (
        $onehot0({issue_valid, instr_storage_irq, data_storage_irq}))
        else $error("Two answers at once");
    a_ready_on_answer: assert property (
        (issue_valid || instr_storage_irq || data_storage_irq) |-> req_ready)
        else $error("Answer without ready");
    a_take_drops_ready: assert property (
        req_valid && req_ready |=> !req_ready)
        else $error("Ready stayed high after take");
    a_branch_redirects: assert property (
        uncond_branch_fetched |=> fetch_redirect && seq_fetch_stop)
        else $error("No redirect after branch");
    a_stop_blocks_fetch: assert property (
        seq_fetch_stop |-> !spec_fetch_allow)
        else $error("Speculation past branch");
    a_trap_blocks_fetch: assert property (
        conditional_trap_instr |=> !spec_fetch_allow)
        else $error("Speculation during trap");
    a_store_not_spec: assert property (
        issue_valid && issue.kind == SAS_STORE |-> !$past(req_speculative))
        else $error("Speculative store issued");
    a_load_miss_spec: assert property (
        issue_valid && issue.kind == SAS_LOAD && issue.allocate |-> !$past(req_speculative))
        else $error("Speculative load miss issued");
    a_write_back_store: assert property (
        issue_valid && issue.kind == SAS_STORE && issue.attr.cacheable
        && !issue.attr.write_through |-> issue.use_cache && !issue.use_memory)
        else $error("Write-back store reached memory");
    a_write_thru_store: assert property (
        issue_valid && issue.kind == SAS_STORE && issue.attr.cacheable
        && issue.attr.write_through |-> issue.use_memory && !issue.allocate)
        else $error("Write-through store wrong");
    a_uncached_memory: assert property (
        issue_valid && !issue.attr.cacheable |-> issue.use_memory && !issue.use_cache)
        else $error("Uncached access used cache");
endmodule

bind sas_spec_ctl sas_spec_ctl_sva u_sva (
    .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_speculative(req_speculative),
    .uncond_branch_fetched(uncond_branch_fetched),
    .conditional_trap_instr(conditional_trap_instr), .req_ready(req_ready),
    .issue_valid(issue_valid), .issue(issue), .instr_storage_irq(instr_storage_irq),
    .data_storage_irq(data_storage_irq), .spec_fetch_allow(spec_fetch_allow),
    .seq_fetch_stop(seq_fetch_stop), .fetch_redirect(fetch_redirect)
);

// *** tb/sas_spec_ctl_tb.sv ***
`timescale 1ns/1ps
module sas_spec_ctl_tb
    import sas_pkg::*;
;
    logic clk, resetn, instruction_relocation_flag, custom_tag_store_exc_enable;
    logic req_valid, req_speculative, req_cache_hit, req_seq_needed;
    logic uncond_branch_fetched, branch_target_fetched, spec_fetch_strobe;
    logic spec_fetch_cacheable, branch_resolved, ctr_branch_predicted, lr_branch_predicted;
    logic ctr_write_issue, ctr_write_done, lr_write_issue, lr_write_done;
    logic conditional_trap_instr, req_ready, issue_valid, instr_storage_irq;
    logic data_storage_irq, spec_fetch_allow, seq_fetch_stop, fetch_redirect;
    logic [31:0]    req_addr, prev_instr_addr;
    logic [7:0]     mem_writes;
    logic [1:0]     ans;
    sas_kind_t      req_kind;
    sas_real_regs_t rm_regs;
    sas_tlb_t       tlb_entry;
    sas_issue_t     issue;
    int             miscompares, n_compared, i, j;

    sas_spec_ctl uut (.*);
    sas_mem_model u_mem (
        .clk(clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
        .mem_writes(mem_writes)
    );

    always #5 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        for (int k = 0; k < n && ans == 2'h0; k++) begin
            tick(1);
            ans = issue_valid ? 2'h1 : instr_storage_irq ? 2'h2 : data_storage_irq ? 2'h3 : 2'h0;
        end
    endtask

    // Answer code: 0 held, 1 issue, 2 instruction fault, 3 data fault
    task automatic acc(input sas_kind_t k, input logic [31:0] a, input logic sp,
                       input logic h, input logic [1:0] ea, input logic [2:0] ef);
        req_valid <= 1'b1;
        req_kind <= k;
        req_addr <= a;
        req_speculative <= sp;
        req_cache_hit <= h;
        tick(1);
        req_valid <= 1'b0;
        ans = 2'h0;
        wt(8);
        chk("answer", 32'(ea), 32'(ans));
        if (ea == 2'h1) begin
            chk("cache_mem_alloc", 32'(ef), 32'({issue.use_cache, issue.use_memory, issue.allocate}));
        end
    endtask

    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        close_out;
    end

    initial begin
        {clk, resetn, instruction_relocation_flag, custom_tag_store_exc_enable} = 4'h0;
        {req_valid, req_speculative, req_cache_hit, req_seq_needed} = 4'h0;
        {uncond_branch_fetched, branch_target_fetched, spec_fetch_strobe} = 3'h0;
        {spec_fetch_cacheable, branch_resolved, ctr_branch_predicted, lr_branch_predicted} = 4'h0;
        {ctr_write_issue, ctr_write_done, lr_write_issue, lr_write_done} = 4'h0;
        conditional_trap_instr = 1'b0;
        req_addr = 32'h0;
        prev_instr_addr = 32'h0;
        req_kind = SAS_FETCH;
        rm_regs = '0;
        tlb_entry = '0;
        miscompares = 0;
        n_compared = 0;
        tick(8);
        resetn <= 1'b1;
        for (i = 0; i < 10 && req_ready !== 1'b1; i++) tick(1);
        rm_regs.data_cacheability_reg <= 32'h0000_0020;
        tick(1);
        acc(SAS_LOAD, 32'h2800_0000, 1'b0, 1'b0, 2'h1, 3'h5);
        acc(SAS_LOAD, 32'h2fff_fffc, 1'b0, 1'b1, 2'h1, 3'h4);
        acc(SAS_LOAD, 32'h3000_0000, 1'b0, 1'b0, 2'h1, 3'h2);
        acc(SAS_STORE, 32'h2800_0000, 1'b0, 1'b0, 2'h1, 3'h5);
        acc(SAS_STORE, 32'h2800_0010, 1'b0, 1'b1, 2'h1, 3'h4);
        chk("mem_writes", 32'h0, 32'(mem_writes));
        rm_regs.write_through_reg <= 32'h0000_0020;
        tick(1);
        acc(SAS_STORE, 32'h2800_0010, 1'b0, 1'b1, 2'h1, 3'h6);
        acc(SAS_STORE, 32'h2800_0020, 1'b0, 1'b0, 2'h1, 3'h2);
        tick(1);
        chk("mem_writes", 32'h2, 32'(mem_writes));
        instruction_relocation_flag <= 1'b1;
        tlb_entry <= 7'h11;
        acc(SAS_LOAD, 32'h3000_0000, 1'b0, 1'b0, 2'h1, 3'h5);
        chk("little_endian", 32'h0, 32'(issue.attr.little_endian));
        tlb_entry <= 7'h03;
        acc(SAS_LOAD, 32'h3000_0000, 1'b0, 1'b0, 2'h1, 3'h5);
        chk("little_endian", 32'h1, 32'(issue.attr.little_endian));
        tlb_entry <= 7'h21;
        acc(SAS_LOAD, 32'h2800_0000, 1'b0, 1'b0, 2'h1, 3'h2);
        tlb_entry <= 7'h09;
        acc(SAS_FETCH, 32'h0000_0100, 1'b0, 1'b0, 2'h2, 3'h0);
        acc(SAS_FETCH, 32'h0000_0100, 1'b1, 1'b1, 2'h1, 3'h4);
        acc(SAS_LOAD, 32'h0000_0200, 1'b1, 1'b1, 2'h1, 3'h4);
        acc(SAS_STORE, 32'h0000_0200, 1'b1, 1'b0, 2'h0, 3'h0);
        req_speculative <= 1'b0;
        wt(4);
        chk("answer", 32'h1, 32'(ans));
        tlb_entry <= 7'h00;
        acc(SAS_FETCH, 32'h0000_0100, 1'b0, 1'b0, 2'h2, 3'h0);
        tlb_entry <= 7'h01;
        acc(SAS_LOAD, 32'h0000_0300, 1'b1, 1'b0, 2'h0, 3'h0);
        req_speculative <= 1'b0;
        wt(4);
        chk("answer", 32'h1, 32'(ans));
        tlb_entry <= 7'h05;
        custom_tag_store_exc_enable <= 1'b1;
        acc(SAS_STORE, 32'h0000_0400, 1'b0, 1'b0, 2'h3, 3'h0);
        custom_tag_store_exc_enable <= 1'b0;
        acc(SAS_STORE, 32'h0000_0400, 1'b0, 1'b0, 2'h1, 3'h5);
        instruction_relocation_flag <= 1'b0;
        rm_regs.real_mode_fence_register <= 32'h0000_0020;
        req_seq_needed <= 1'b1;
        prev_instr_addr <= 32'h2800_03fc;
        acc(SAS_FETCH, 32'h2800_0400, 1'b1, 1'b0, 2'h1, 3'h2);
        prev_instr_addr <= 32'h2800_0000;
        acc(SAS_FETCH, 32'h2800_0800, 1'b1, 1'b0, 2'h0, 3'h0);
        req_speculative <= 1'b0;
        wt(4);
        chk("answer", 32'h1, 32'(ans));
        req_seq_needed <= 1'b0;
        acc(SAS_FETCH, 32'h3000_0000, 1'b1, 1'b0, 2'h1, 3'h2);
        for (j = 0; j < 2; j++) begin
            spec_fetch_cacheable <= (j == 0);
            branch_resolved <= 1'b1;
            tick(1);
            branch_resolved <= 1'b0;
            spec_fetch_strobe <= 1'b1;
            tick((j == 0) ? 4 : 1);
            spec_fetch_strobe <= 1'b0;
            tick(2);
            chk("allow_below_max", 32'h1, 32'(spec_fetch_allow));
            spec_fetch_strobe <= 1'b1;
            tick(1);
            spec_fetch_strobe <= 1'b0;
            tick(2);
            chk("allow_at_max", 32'h0, 32'(spec_fetch_allow));
        end
        branch_resolved <= 1'b1;
        tick(1);
        branch_resolved <= 1'b0;
        for (j = 0; j < 2; j++) begin
            ctr_branch_predicted <= (j == 0);
            lr_branch_predicted <= (j == 1);
            ctr_write_issue <= (j == 0);
            lr_write_issue <= (j == 1);
            tick(1);
            {ctr_write_issue, lr_write_issue} <= 2'h0;
            tick(2);
            chk("allow_pending", 32'h0, 32'(spec_fetch_allow));
            ctr_write_done <= (j == 0);
            lr_write_done <= (j == 1);
            tick(1);
            {ctr_write_done, lr_write_done} <= 2'h0;
            tick(2);
            chk("allow_updated", 32'h1, 32'(spec_fetch_allow));
        end
        conditional_trap_instr <= 1'b1;
        tick(2);
        chk("allow_trap", 32'h0, 32'(spec_fetch_allow));
        conditional_trap_instr <= 1'b0;
        uncond_branch_fetched <= 1'b1;
        tick(1);
        uncond_branch_fetched <= 1'b0;
        chk("redirect", 32'h1, 32'(fetch_redirect));
        chk("seq_stop", 32'h1, 32'(seq_fetch_stop));
        tick(2);
        chk("allow_stop", 32'h0, 32'(spec_fetch_allow));
        branch_target_fetched <= 1'b1;
        tick(1);
        branch_target_fetched <= 1'b0;
        tick(1);
        chk("seq_stop", 32'h0, 32'(seq_fetch_stop));
        close_out;
    end
endmodule
